// ===== inc/uxu_pkg.sv
// Constants, register map and carrier types of the two-wire shift unit.
// Assumes an APB slave with 32-bit data; each register takes one word.
package uxu_pkg;
	// ----------------------------------------
	// Register map: index, byte address is index * 4
	// ----------------------------------------
	localparam int          ADDR_W    = 8;
	localparam logic [5:0]  IDX_CTRL  = 6'h0D;
	localparam logic [5:0]  IDX_STAT  = 6'h0E;
	localparam logic [5:0]  IDX_DATA  = 6'h0F;
	localparam logic [5:0]  IDX_RXBUF = 6'h10;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int          B_START   = 7;
	localparam int          B_OVF     = 6;
	localparam int          B_STOP    = 5;
	localparam int          B_SCLK    = 1;
	localparam int          B_TOG     = 0;
	localparam logic [3:0]  CNT_MAX   = 4'hF;
	localparam logic [3:0]  CNT_RST   = 4'h0;
	localparam logic [7:0]  BYTE_RST  = 8'h00;
	localparam logic [2:0]  SYNC_INIT = 3'h3;

	// Wire mode encodings
	typedef enum logic [1:0] {
		WM_OFF,
		WM_THREE,
		WM_TWO,
		WM_TWO_OVF
	} uxu_wm_t;

	// Clock source encodings
	typedef enum logic [1:0] {
		CS_SOFT,
		CS_TIMER,
		CS_EXT_POS,
		CS_EXT_NEG
	} uxu_cs_t;

	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic    startIrqEnable;
		logic    overflowIrqEnable;
		uxu_wm_t wireModeSelect;
		uxu_cs_t clockSourceSelect;
		logic    softClockStrobe;
		logic    clockToggleStrobe;
	} uxu_ctrl_t;

	// Port-side settings that steer the pin drivers
	typedef struct packed {
		logic sclDir;
		logic sdaDir;
		logic sdaPortBit;
	} uxu_port_t;
endpackage : uxu_pkg

// ===== hdl/uxu_sync3.sv
// Three-stage synchroniser with agreement filter for pin levels.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module uxu_sync3 #(
	parameter int             W    = 3,
	parameter logic [W-1:0]   INIT = '0
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         arst_n,
	// Levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1Q;
	logic [W-1:0] s2Q;
	logic [W-1:0] s3Q;

	// First stage feeds only the second; a change counts when stages agree
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1Q  <= INIT;
			s2Q  <= INIT;
			s3Q  <= INIT;
			dout <= INIT;
		end else begin
			s1Q <= din;
			s2Q <= s1Q;
			s3Q <= s2Q;
			for (int i = 0; i < W; i++) begin
				if (s2Q[i] == s3Q[i]) begin
					dout[i] <= s3Q[i];
				end
			end
		end
	end
endmodule : uxu_sync3
`default_nettype wire

// ===== hdl/uxu_start_latch.sv
// Clockless start condition latch: data line falling while clock is high.
// Assumes clrN comes from a flip-flop so that the clear never glitches.
`timescale 1ns/1ps
`default_nettype none
module uxu_start_latch (
	// Bus lines, raw
	input  wire logic sdaLine,
	input  wire logic sclLine,
	// Control
	input  wire logic enable,
	input  wire logic clrN,
	// Result
	output logic      detected
);
	// Clocked by the data line itself so it works with sys_clk stopped
	always_ff @(negedge sdaLine or negedge clrN) begin
		if (!clrN) begin
			detected <= 1'b0;
		end else begin
			detected <= detected | (enable & sclLine);
		end
	end
endmodule : uxu_start_latch
`default_nettype wire

// ===== hdl/uxu_shift_unit.sv
// Universal serial shift unit, two-wire capable, behind an APB slave.
// Assumes the bus lines are open drain with pull-ups outside the block.
`timescale 1ns/1ps
`default_nettype none
module uxu_shift_unit (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     arst_n,
	// APB slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [uxu_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Bus pins
	input  wire logic                     sclI,
	output logic                          sclO,
	output logic                          sclOe,
	input  wire logic                     sdaI,
	output logic                          sdaO,
	output logic                          sdaOe,
	output logic                          doOut,
	// System side
	input  wire uxu_pkg::uxu_port_t       portCfg,
	input  wire logic                     timerMatch,
	input  wire logic                     globalIrqEn,
	output logic                          startIrq,
	output logic                          ovfIrq,
	output logic                          wakeReq
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	uxu_pkg::uxu_ctrl_t ctrl_q;
	uxu_pkg::uxu_ctrl_t ctrlEff;
	logic [7:0]  shift_q;
	logic [7:0]  shift_d;
	logic [7:0]  rxBuf_q;
	logic [3:0]  cnt_q;
	logic        startFlag_q;
	logic        ovfFlag_q;
	logic        stopFlag_q;
	logic        startHold_q;
	logic        clrLatchN_q;
	logic        portScl_q;
	logic        sclPrev_q;
	logic        sdaPrev_q;
	logic        detPrev_q;
	logic        startDet;
	logic [2:0]  syncOut;
	logic        sclS;
	logic        sdaS;
	logic        detS;
	logic [5:0]  idx;
	logic        mapped;
	logic        wrEn;
	logic        wrCtrl;
	logic        wrStat;
	logic        wrData;
	logic        twoWire;
	logic        sclRise;
	logic        sclFall;
	logic        stopEvt;
	logic        startEvt;
	logic        edgeEvt;
	logic        shiftClk;
	logic        cntClk;
	logic        ovfEvt;
	logic        ovfHold;
	logic        latchOpen;
	logic [7:0]  rdMux;

	// ----------------------------------------
	// Pin synchronisers and start detector
	// ----------------------------------------
	// Start latch runs without sys_clk so it can wake a stopped core
	uxu_start_latch u_start (
		.sdaLine  (sdaI),
		.sclLine  (sclI),
		.enable   (twoWire),
		.clrN     (clrLatchN_q),
		.detected (startDet)
	);

	// Lines idle high, so they reset high to avoid a false first edge
	uxu_sync3 #(.W(3), .INIT(uxu_pkg::SYNC_INIT)) u_sync (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.din     ({startDet, sdaI, sclI}),
		.dout    (syncOut)
	);
	assign sclS    = syncOut[0];
	assign sdaS    = syncOut[1];
	assign detS    = syncOut[2];
	assign wakeReq = startDet;

	// Edge memory of the synchronised levels
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
			detPrev_q <= 1'b0;
		end else begin
			sclPrev_q <= sclS;
			sdaPrev_q <= sdaS;
			detPrev_q <= detS;
		end
	end

	// ----------------------------------------
	// Decode and event terms
	// ----------------------------------------
	assign idx     = paddr[7:2];
	assign mapped  = (paddr[1:0] == 2'h0) && (idx == uxu_pkg::IDX_CTRL || idx == uxu_pkg::IDX_STAT
	                 || idx == uxu_pkg::IDX_DATA || idx == uxu_pkg::IDX_RXBUF);
	assign wrEn    = psel & penable & pready & pwrite & mapped;
	assign wrCtrl  = wrEn && idx == uxu_pkg::IDX_CTRL;
	assign wrStat  = wrEn && idx == uxu_pkg::IDX_STAT;
	assign wrData  = wrEn && idx == uxu_pkg::IDX_DATA;
	// A control write with strobes acts under the settings it writes
	assign ctrlEff = wrCtrl ? uxu_pkg::uxu_ctrl_t'(pwdata[7:0]) : ctrl_q;
	assign twoWire = ctrl_q.wireModeSelect[1];
	assign sclRise = sclS & ~sclPrev_q;
	assign sclFall = ~sclS & sclPrev_q;
	assign edgeEvt = sclRise | sclFall;
	assign stopEvt = twoWire & sclS & sclPrev_q & sdaS & ~sdaPrev_q;
	assign startEvt = twoWire & detS & ~detPrev_q;
	assign ovfHold = ctrl_q.wireModeSelect == uxu_pkg::WM_TWO_OVF && ovfFlag_q;

	// Clock source selection for shift register and counter
	always_comb begin
		shiftClk = 1'b0;
		cntClk   = 1'b0;
		case (ctrlEff.clockSourceSelect)
			uxu_pkg::CS_SOFT: begin
				shiftClk = wrCtrl & pwdata[uxu_pkg::B_SCLK];
				cntClk   = shiftClk;
			end
			uxu_pkg::CS_TIMER: begin
				shiftClk = timerMatch;
				cntClk   = timerMatch;
			end
			uxu_pkg::CS_EXT_POS, uxu_pkg::CS_EXT_NEG: begin
				// Pins drive shifting in every wire mode, disabled included
				shiftClk = ctrlEff.clockSourceSelect[0] ? sclFall : sclRise;
				cntClk   = ctrlEff.softClockStrobe ? (wrCtrl & pwdata[uxu_pkg::B_TOG])
				                                   : edgeEvt;
			end
			default: begin
				shiftClk = 1'b0;
				cntClk   = 1'b0;
			end
		endcase
	end

	// Next shift value; a CPU write wins over a coincident shift
	always_comb begin
		shift_d = shift_q;
		if (wrData) begin
			shift_d = pwdata[7:0];
		end else if (shiftClk) begin
			shift_d = {shift_q[6:0], sdaS};
		end
	end

	assign ovfEvt = cntClk & ~wrStat & (cnt_q == uxu_pkg::CNT_MAX);

	// ----------------------------------------
	// Control, data and counter registers
	// ----------------------------------------
	// Strobe bit is not stored; the clock select bit is
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= uxu_pkg::uxu_ctrl_t'(uxu_pkg::BYTE_RST);
		end else if (wrCtrl) begin
			ctrl_q <= uxu_pkg::uxu_ctrl_t'({pwdata[7:1], 1'b0});
		end
	end

	// Shift register and receive buffer
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_q <= uxu_pkg::BYTE_RST;
			rxBuf_q <= uxu_pkg::BYTE_RST;
		end else begin
			shift_q <= shift_d;
			if (ovfEvt) begin
				rxBuf_q <= shift_d;
			end
		end
	end

	// Counter: software write wins over a count
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= uxu_pkg::CNT_RST;
		end else if (wrStat) begin
			cnt_q <= pwdata[3:0];
		end else if (cntClk) begin
			cnt_q <= 4'(cnt_q + 4'h1);
		end
	end

	// ----------------------------------------
	// Status flags, set wins over clear
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			startFlag_q <= 1'b0;
			ovfFlag_q   <= 1'b0;
			stopFlag_q  <= 1'b0;
		end else begin
			startFlag_q <= startEvt | (~twoWire & ctrl_q.clockSourceSelect[1]
			               & ~ctrl_q.softClockStrobe & edgeEvt)
			               | (startFlag_q & ~(wrStat & pwdata[uxu_pkg::B_START]));
			ovfFlag_q   <= ovfEvt | (ovfFlag_q & ~(wrStat & pwdata[uxu_pkg::B_OVF]));
			stopFlag_q  <= stopEvt | (stopFlag_q & ~(wrStat & pwdata[uxu_pkg::B_STOP]));
		end
	end

	// Start hold arms at the first falling clock edge after a start
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			startHold_q <= 1'b0;
		end else if (!startFlag_q || !twoWire) begin
			startHold_q <= 1'b0;
		end else if (sclFall) begin
			startHold_q <= 1'b1;
		end
	end

	// Latch clear pulses when software clears the flag; held clear outside two-wire
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			clrLatchN_q <= 1'b0;
		end else begin
			clrLatchN_q <= twoWire & ~(wrStat & pwdata[uxu_pkg::B_START]);
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// Port clock bit idles high and toggles on the toggle strobe
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			portScl_q <= 1'b1;
		end else if (wrCtrl && pwdata[uxu_pkg::B_TOG]) begin
			portScl_q <= ~portScl_q;
		end
	end

	// Latch open in first half-cycle for external clock, always for internal
	assign latchOpen = ~ctrl_q.clockSourceSelect[1] | (sclS == ctrl_q.clockSourceSelect[0]);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			doOut <= 1'b1;
		end else if (latchOpen) begin
			doOut <= shift_d[7];
		end
	end

	// Open drain in two-wire mode: only ever pull low; push-pull otherwise
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclO  <= 1'b0;
			sclOe <= 1'b0;
			sdaO  <= 1'b0;
			sdaOe <= 1'b0;
		end else begin
			sclO  <= twoWire ? 1'b0 : portScl_q;
			sclOe <= portCfg.sclDir & (~twoWire | ~portScl_q | startHold_q | ovfHold);
			sdaO  <= twoWire ? 1'b0 : portCfg.sdaPortBit;
			sdaOe <= portCfg.sdaDir & (~twoWire | ~doOut | ~portCfg.sdaPortBit);
		end
	end

	// Interrupt requests; the stop flag never raises one
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			startIrq <= 1'b0;
			ovfIrq   <= 1'b0;
		end else begin
			startIrq <= startFlag_q & ctrl_q.startIrqEnable & globalIrqEn;
			ovfIrq   <= ovfFlag_q & ctrl_q.overflowIrqEnable & globalIrqEn;
		end
	end

	// ----------------------------------------
	// APB read path, one wait state per access
	// ----------------------------------------
	always_comb begin
		case (idx)
			uxu_pkg::IDX_CTRL:  rdMux = {ctrl_q[7:2], 2'h0};
			uxu_pkg::IDX_STAT:  rdMux = {startFlag_q, ovfFlag_q, stopFlag_q,
			                             shift_q[7] ^ sdaS, cnt_q};
			uxu_pkg::IDX_DATA:  rdMux = shift_q;
			uxu_pkg::IDX_RXBUF: rdMux = rxBuf_q;
			default:            rdMux = uxu_pkg::BYTE_RST;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			prdata  <= (mapped & ~pwrite) ? {24'h000000, rdMux} : 32'h00000000;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	sequence sStartSeen;
		twoWire && startEvt ##1 startFlag_q;
	endsequence
	sequence sMasterFall;
		sclFall && startFlag_q && twoWire ##1 startHold_q;
	endsequence

	AST_START_SET: assert property (twoWire && startEvt |-> sStartSeen)
		else $error("start event did not set flag");
	AST_START_HOLD: assert property (sMasterFall ##0 portCfg.sclDir |=> sclOe)
		else $error("clock not held after start");
	AST_START_CLR: assert property (wrStat && pwdata[uxu_pkg::B_START] && !startEvt && twoWire
		|=> !startFlag_q ##1 !startHold_q)
		else $error("start flag clear failed");
	AST_START_IRQ: assert property (startFlag_q && ctrl_q.startIrqEnable && globalIrqEn |=> startIrq)
		else $error("start irq missing");
	AST_OVF_SET: assert property (ovfEvt |=> ovfFlag_q && cnt_q == uxu_pkg::CNT_RST)
		else $error("overflow not flagged");
	AST_OVF_HOLD: assert property (ovfHold && portCfg.sclDir |=> sclOe)
		else $error("overflow hold missing");
	AST_STOP_SET: assert property (stopEvt && !startFlag_q && !ovfFlag_q && !startEvt && !ovfEvt
		|=> stopFlag_q ##1 !startIrq && !ovfIrq)
		else $error("stop flag not set");
	AST_CNT_WR: assert property (wrStat |=> cnt_q == $past(pwdata[3:0]))
		else $error("counter write lost");
	AST_RXBUF: assert property (ovfEvt |=> rxBuf_q == shift_q)
		else $error("buffer not loaded");
	AST_WR_WINS: assert property (wrData |=> shift_q == $past(pwdata[7:0]))
		else $error("shift beat cpu write");
endmodule : uxu_shift_unit
`default_nettype wire

// ===== verification/uxu_bus_master_model.sv
// Behavioural two-wire bus master that pulls SCL and SDA low on request.
// Assumes the bench resolves both lines as wired-AND with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module uxu_bus_master_model (
	// Resolved clock line
	input  wire logic sclLine,
	// Pull-down requests, high pulls the line low
	output logic      sclDrv,
	output logic      sdaDrv,
	// Set when the clock line never rose
	output logic      stuck
);
	// ----------------------------------------
	// Link timing
	// ----------------------------------------
	localparam int HALF = 80;

	// Idle bus: both lines released
	initial begin
		sclDrv = 1'b0;
		sdaDrv = 1'b0;
		stuck  = 1'b0;
	end

	// Release the clock and wait for it to rise; a slave may stretch it
	task automatic rel_scl;
		int i;
		sclDrv = 1'b0;
		i = 0;
		while (sclLine !== 1'b1 && i < 500) begin
			#10;
			i++;
		end
		if (i >= 500)
			stuck = 1'b1;
	endtask : rel_scl

	// Data falls while clock is high, then clock falls
	task automatic start_cond;
		#13 sdaDrv = 1'b1;
		#(HALF) sclDrv = 1'b1;
		#(HALF);
	endtask : start_cond

	// One clock pulse, data untouched
	task automatic clk_pulse;
		#13 sclDrv = 1'b1;
		#(HALF) rel_scl();
		#(HALF);
	endtask : clk_pulse

	// Data changes only while the clock is low
	task automatic send_bit(input logic b);
		#23 sdaDrv = ~b;
		#57 rel_scl();
		#(HALF) sclDrv = 1'b1;
	endtask : send_bit

	// Most significant bit first
	task automatic send_byte(input logic [7:0] b);
		for (int k = 7; k >= 0; k--) begin
			send_bit(b[k]);
		end
	endtask : send_byte

	// Data rises while clock is high
	task automatic stop_cond;
		#23 sdaDrv = 1'b1;
		#57 rel_scl();
		#(HALF) sdaDrv = 1'b0;
		#(HALF);
	endtask : stop_cond
endmodule : uxu_bus_master_model
`default_nettype wire

// ===== verification/uxu_shift_unit_tb.sv
// Self-checking bench for the shift unit: APB tasks and a two-wire master.
// Assumes open-drain lines with pull-ups, resolved here from all drivers.
`timescale 1ns/1ps
`default_nettype none
module uxu_shift_unit_tb;
	// ----------------------------------------
	// Signals and addresses
	// ----------------------------------------
	logic                          sys_clk, arst_n, psel, penable, pwrite;
	logic [uxu_pkg::ADDR_W-1:0]    paddr;
	logic [31:0]                   pwdata, prdata, rdat;
	logic                          pready, pslverr, err, sclO, sclOe, sdaO, sdaOe, doOut;
	logic                          timerMatch, globalIrqEn, startIrq, ovfIrq, wakeReq;
	logic                          mScl, mSda, mStuck;
	uxu_pkg::uxu_port_t            portCfg;
	wire logic                     sclLine, sdaLine;
	int                            error_cnt, n_checks;
	localparam logic [7:0] A_CTRL = {uxu_pkg::IDX_CTRL, 2'h0};
	localparam logic [7:0] A_STAT = {uxu_pkg::IDX_STAT, 2'h0};
	localparam logic [7:0] A_DATA = {uxu_pkg::IDX_DATA, 2'h0};
	localparam logic [7:0] A_RXB  = {uxu_pkg::IDX_RXBUF, 2'h0};

	// Wired-AND lines; released lines go high through the pull-ups
	assign sclLine = ~(sclOe & ~sclO) & ~mScl;
	assign sdaLine = ~(sdaOe & ~sdaO) & ~mSda;

	uxu_shift_unit dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclI(sclLine), .sclO(sclO), .sclOe(sclOe), .sdaI(sdaLine),
		.sdaO(sdaO), .sdaOe(sdaOe), .doOut(doOut), .portCfg(portCfg), .timerMatch(timerMatch),
		.globalIrqEn(globalIrqEn), .startIrq(startIrq), .ovfIrq(ovfIrq), .wakeReq(wakeReq));

	uxu_bus_master_model mst_u (.sclLine(sclLine), .sclDrv(mScl), .sdaDrv(mSda), .stuck(mStuck));

	// ----------------------------------------
	// Report and compare tasks
	// ----------------------------------------
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	task automatic fail(input string m);
		error_cnt++;
		$display("wrong value at %0t: %s", $time, m);
	endtask : fail

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp)
			fail(m);
	endtask : chk

	task automatic chkb(input logic got, input logic exp, input string m);
		n_checks++;
		if (got !== exp)
			fail(m);
	endtask : chkb

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int i;
		@(posedge sys_clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rdat    = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (i >= 20) begin
			fail("no pready");
			stop_test();
		end
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h000000, d});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp, input string m);
		apb(1'b0, a, 32'h00000000);
		chk(rdat & {24'hFFFFFF, mask}, {24'h000000, exp}, m);
	endtask : rd

	// 50 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{arst_n, psel, penable, pwrite, timerMatch} = 5'h00;
		paddr       = 8'h00;
		pwdata      = 32'h00000000;
		globalIrqEn = 1'b1;
		portCfg     = '{sclDir: 1'b1, sdaDir: 1'b0, sdaPortBit: 1'b1};
		error_cnt   = 0;
		n_checks    = 0;
		cyc(10);
		arst_n <= 1'b1;
		cyc(5);
		// Reset values; collision is live so it is masked
		rd(A_STAT, 8'hEF, 8'h00, "stat reset");
		rd(A_CTRL, 8'hFF, 8'h00, "ctrl reset");
		rd(A_DATA, 8'hFF, 8'h00, "data reset");
		rd(A_RXB, 8'hFF, 8'h00, "rxbuf reset");
		// Unmapped and misaligned addresses are refused
		rd(8'h44, 8'hFF, 8'h00, "unmapped data");
		chkb(err, 1'b1, "unmapped err");
		rd(8'h39, 8'hFF, 8'h00, "misaligned data");
		chkb(err, 1'b1, "misaligned err");
		// Soft strobe at counter maximum: shift, wrap, flag, buffer copy
		wr(A_STAT, 8'h0F);
		rd(A_STAT, 8'hEF, 8'h0F, "counter write");
		wr(A_DATA, 8'h81);
		cyc(2);
		chkb(doOut, 1'b1, "latch open");
		wr(A_CTRL, 8'h42);
		cyc(2);
		chkb(doOut, 1'b0, "latch shifted");
		chkb(ovfIrq, 1'b1, "ovf irq");
		rd(A_DATA, 8'hFF, 8'h03, "soft shift");
		rd(A_STAT, 8'hEF, 8'h40, "wrap flag");
		rd(A_RXB, 8'hFF, 8'h03, "buffer copy");
		wr(A_STAT, 8'h40);
		cyc(2);
		chkb(ovfIrq, 1'b0, "ovf irq clear");
		rd(A_STAT, 8'hEF, 8'h00, "ovf clear");
		// Timer compare match as clock source
		wr(A_CTRL, 8'h04);
		repeat (3) begin
			@(posedge sys_clk) timerMatch <= 1'b1;
			@(posedge sys_clk) timerMatch <= 1'b0;
			cyc(2);
		end
		rd(A_STAT, 8'hEF, 8'h03, "timer count");
		rd(A_DATA, 8'hFF, 8'h1F, "timer shift");
		// External source with toggle strobe counting, toggled twice
		wr(A_CTRL, 8'h0B);
		cyc(8);
		wr(A_CTRL, 8'h0B);
		cyc(8);
		rd(A_STAT, 8'hEF, 8'h05, "toggle count");
		// Disabled outputs, external negative edge: any edge sets start
		wr(A_STAT, 8'h00);
		wr(A_DATA, 8'h00);
		wr(A_CTRL, 8'h0C);
		mst_u.clk_pulse();
		cyc(6);
		rd(A_STAT, 8'hEF, 8'h82, "edge start, both edges");
		rd(A_DATA, 8'hFF, 8'h01, "disabled mode shift");
		wr(A_STAT, 8'h80);
		// Two-wire mode with overflow hold, start interrupt enabled
		wr(A_CTRL, 8'hB8);
		cyc(5);
		mst_u.start_cond();
		chkb(wakeReq, 1'b1, "wake");
		cyc(6);
		chkb(sclOe, 1'b1, "start hold");
		chkb(startIrq, 1'b1, "start irq");
		rd(A_STAT, 8'hEF, 8'h81, "start flag");
		wr(A_STAT, 8'h80);
		cyc(3);
		chkb(sclOe, 1'b0, "start release");
		chkb(startIrq, 1'b0, "start irq clear");
		mst_u.send_byte(8'hA5);
		cyc(8);
		chkb(sclOe, 1'b1, "overflow hold");
		rd(A_STAT, 8'hFF, 8'h40, "byte overflow");
		rd(A_RXB, 8'hFF, 8'hA5, "byte buffered");
		wr(A_DATA, 8'h00);
		rd(A_STAT, 8'hFF, 8'h50, "collision");
		// Slave acknowledge: data pin enabled while the open latch shows a zero MSB
		portCfg.sdaDir <= 1'b1;
		cyc(3);
		chkb(sdaOe, 1'b1, "ack drive");
		chkb(sdaLine | sdaO | sclO, 1'b0, "open drain low");
		wr(A_DATA, 8'h80);
		cyc(3);
		chkb(sdaOe, 1'b0, "ack release");
		wr(A_STAT, 8'h4E);
		cyc(3);
		chkb(sclOe, 1'b0, "overflow release");
		mst_u.stop_cond();
		cyc(6);
		rd(A_STAT, 8'hFF, 8'h3F, "stop flag");
		chkb(startIrq | ovfIrq, 1'b0, "stop no irq");
		chkb(mStuck, 1'b0, "clock stretch");
		stop_test();
	end
endmodule : uxu_shift_unit_tb
`default_nettype wire
